//--- core/rsf_pkg.sv
// constants for the receive status flag block
//
// How it works
// - receive-full sets when a finished frame lands in the data register.
// - receive-full clears on status read with it set, then data-low read.
// - idle sets after 10 ones (short frame) or 11 ones (long frame).
// - after idle clears, it waits for a new receive-full before setting again.
// - idle clears on status read with it set, then data-low read.
// - standby mode keeps the idle flag from setting.
// - overrun sets when a second frame ends while the first is unread.
// - an overrun frame is dropped; data registers keep the old frame.
// - overrun clears on status read with it set, then data-low read.
// - overrun set at or after status read survives; needs another read pair.
// - noise sets together with receive-full, never on overrun.
// - noise clears on status read then data-low read.
// - framing fault sets with receive-full on a zero stop bit, never on overrun.
// - while framing fault is set no further frame is taken.
// - framing fault clears on status read with it set, then data-low read.
// - parity fault sets with receive-full on bad parity, never on overrun.
// - parity fault clears on status read then data-low read.
// - writes to the status register change nothing.
// - receive irq enable raises a request while receive-full or overrun is set.
// - idle irq enable raises a request while idle is set.
package rsf_pkg;
   // register offsets
   localparam logic [3:0] REG_CTRL      = 4'h3;
   localparam logic [3:0] REG_STATUS    = 4'h4;
   localparam logic [3:0] REG_DATA_HIGH = 4'h6;
   localparam logic [3:0] REG_DATA_LOW  = 4'h7;
   // status bit positions
   localparam int ST_RX_FULL  = 5;
   localparam int ST_IDLE     = 4;
   localparam int ST_OVERRUN  = 3;
   localparam int ST_NOISE    = 2;
   localparam int ST_FRAMING  = 1;
   localparam int ST_PARITY   = 0;
   localparam int NUM_FLAGS   = 6;
   // control bit positions
   localparam int CT_FRAME_LEN   = 7;
   localparam int CT_RX_IRQ_EN   = 5;
   localparam int CT_IDLE_IRQ_EN = 4;
   localparam int CT_PARITY_EN   = 3;
   localparam int CT_PARITY_SENSE = 2;
   localparam int CT_STANDBY     = 1;
   // values after reset
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [8:0] DATA_RESET  = 9'h000;
   // idle line length in bit times
   localparam logic [3:0] IDLE_BITS_SHORT = 4'hA;
   localparam logic [3:0] IDLE_BITS_LONG  = 4'hB;
endpackage

//--- core/rsf_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rsf_sync
   import rsf_pkg::*;
#(
   parameter int   WIDTH     = 1,
   parameter logic RESET_VAL = 1'b1
)
(
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   initial
   begin
      if (WIDTH < 1)
         $error("rsf_sync: WIDTH must be at least 1");
   end

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1   <= {WIDTH{RESET_VAL}};
         sync_out <= {WIDTH{RESET_VAL}};
      end
      else
      begin
         stage1   <= pin_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

//--- core/rsf_idle_det.sv
// counter of consecutive high bit times on the receive line
`timescale 1ns/1ps
`default_nettype none
module rsf_idle_det
   import rsf_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic line_high,
   input  wire logic bit_tick,
   input  wire logic long_frame,
   output logic      idle_hit
);
   logic [3:0] ones_cnt;
   logic [3:0] limit;

   assign limit = long_frame ? IDLE_BITS_LONG : IDLE_BITS_SHORT;

   // counter stops at the limit so one idle stretch gives one pulse
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         ones_cnt <= 4'h0;
      else if (!line_high)
         ones_cnt <= 4'h0;
      else if (bit_tick && ones_cnt < limit)
         ones_cnt <= ones_cnt + 4'h1;
   end

   // pulse on the bit time that completes the idle stretch
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         idle_hit <= 1'b0;
      else
         idle_hit <= line_high && bit_tick && (ones_cnt == limit - 4'h1);
   end
endmodule
`default_nettype wire

//--- core/rsf_top.sv
// receive status flags, data holding register and register port
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rsf_top
   import rsf_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   // receive line pin
   input  wire logic              rx_line,
   // from the receive shifter, same clock
   input  wire logic              rx_bit_tick,
   input  wire logic              rx_frame_done,
   input  wire logic [8:0]        rx_frame_data,
   input  wire logic              rx_frame_noise,
   input  wire logic              rx_frame_stop,
   // to the receive shifter
   output logic                   rx_accept_en,
   output logic                   frame_len_sel,
   output logic                   parity_enable,
   output logic                   parity_sense,
   output logic                   receiver_standby,
   // interrupt requests
   output logic                   rx_irq,
   output logic                   idle_irq
);
   // control register
   logic [7:0] ctrl;
   // flags and snapshot taken at the status read
   logic [NUM_FLAGS-1:0] flags;
   logic [NUM_FLAGS-1:0] armed;
   logic [NUM_FLAGS-1:0] clr;
   // received data held for software
   logic [8:0] rx_data;
   // idle may set only after a frame since the last idle clear
   logic idle_allow;
   // synchronised line and idle pulse
   logic line_sync;
   logic idle_hit;
   // decoded accesses
   logic status_rd;
   logic data_low_rd;
   logic ctrl_wr;
   // frame events
   logic frame_take;
   logic full_set;
   logic ovr_set;
   logic noise_set;
   logic fault_set;
   logic parity_set;
   logic idle_set;
   logic parity_bad;
   logic [7:0] next_rdata;

   initial
   begin
      if (ADDR_W < 4)
         $error("rsf_top: ADDR_W must be at least 4");
   end

   // receive line comes from a pin, so it is synchronised first
   rsf_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b1)
   ) u_line_sync (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .pin_in   (rx_line),
      .sync_out (line_sync)
   );

   // idle line detector
   rsf_idle_det u_idle (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .line_high  (line_sync),
      .bit_tick   (rx_bit_tick),
      .long_frame (ctrl[CT_FRAME_LEN]),
      .idle_hit   (idle_hit)
   );

   // address decode; upper address bits must be zero
   assign status_rd   = reg_rd && (reg_addr == ADDR_W'(REG_STATUS));
   assign data_low_rd = reg_rd && (reg_addr == ADDR_W'(REG_DATA_LOW));
   assign ctrl_wr     = reg_wr && (reg_addr == ADDR_W'(REG_CTRL));

   // parity bit is the last data bit of the frame
   always_comb
   begin
      if (ctrl[CT_FRAME_LEN])
         parity_bad = (^rx_frame_data[8:0]) ^ ctrl[CT_PARITY_SENSE];
      else
         parity_bad = (^rx_frame_data[7:0]) ^ ctrl[CT_PARITY_SENSE];
   end

   // frames are refused while a framing fault stands
   assign frame_take = rx_frame_done && !flags[ST_FRAMING];

   // a frame either fills the register or overruns it
   assign full_set   = frame_take && !flags[ST_RX_FULL];
   assign ovr_set    = frame_take && flags[ST_RX_FULL];
   // error flags only ride with a frame that was stored
   assign noise_set  = full_set && rx_frame_noise;
   assign fault_set  = full_set && !rx_frame_stop;
   assign parity_set = full_set && ctrl[CT_PARITY_EN] && parity_bad;
   // idle needs a fresh frame and no standby
   assign idle_set   = idle_hit && idle_allow && !ctrl[CT_STANDBY];

   // a data-low read clears only what the status read saw set
   assign clr = data_low_rd ? armed : '0;

   // control register; writes to status fall through untouched
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         ctrl <= CTRL_RESET;
      else if (ctrl_wr)
         ctrl <= reg_wdata;
   end

   // snapshot of the flags seen by software at the status read
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         armed <= FLAGS_RESET;
      else if (status_rd)
         armed <= flags;
      else if (data_low_rd)
         armed <= FLAGS_RESET;
   end

   // receive-full flag; set wins over the clear
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         flags[ST_RX_FULL] <= 1'b0;
      else if (full_set)
         flags[ST_RX_FULL] <= 1'b1;
      else if (clr[ST_RX_FULL])
         flags[ST_RX_FULL] <= 1'b0;
   end

   // idle flag
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         flags[ST_IDLE] <= 1'b0;
      else if (idle_set)
         flags[ST_IDLE] <= 1'b1;
      else if (clr[ST_IDLE])
         flags[ST_IDLE] <= 1'b0;
   end

   // idle permission: a stored frame reopens it, an idle clear closes it
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         idle_allow <= 1'b0;
      else if (full_set)
         idle_allow <= 1'b1;
      else if (clr[ST_IDLE] && !idle_set)
         idle_allow <= 1'b0;
   end

   // overrun flag; a clear in the same cycle loses to a new overrun
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         flags[ST_OVERRUN] <= 1'b0;
      else if (ovr_set)
         flags[ST_OVERRUN] <= 1'b1;
      else if (clr[ST_OVERRUN])
         flags[ST_OVERRUN] <= 1'b0;
   end

   // noise flag
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         flags[ST_NOISE] <= 1'b0;
      else if (noise_set)
         flags[ST_NOISE] <= 1'b1;
      else if (clr[ST_NOISE])
         flags[ST_NOISE] <= 1'b0;
   end

   // framing fault flag
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         flags[ST_FRAMING] <= 1'b0;
      else if (fault_set)
         flags[ST_FRAMING] <= 1'b1;
      else if (clr[ST_FRAMING])
         flags[ST_FRAMING] <= 1'b0;
   end

   // parity fault flag
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         flags[ST_PARITY] <= 1'b0;
      else if (parity_set)
         flags[ST_PARITY] <= 1'b1;
      else if (clr[ST_PARITY])
         flags[ST_PARITY] <= 1'b0;
   end

   // data register loads only when empty, so an overrun keeps the old frame
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         rx_data <= DATA_RESET;
      else if (full_set)
         rx_data <= rx_frame_data;
   end

   // read mux; data stand only in the cycle after the strobe
   always_comb
   begin
      next_rdata = 8'h00;
      if (reg_rd)
      begin
         if (reg_addr == ADDR_W'(REG_STATUS))
            next_rdata = {2'b00, flags};
         else if (reg_addr == ADDR_W'(REG_CTRL))
            next_rdata = ctrl;
         else if (reg_addr == ADDR_W'(REG_DATA_HIGH))
            next_rdata = {rx_data[8], 7'h00};
         else if (reg_addr == ADDR_W'(REG_DATA_LOW))
            next_rdata = rx_data[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= next_rdata;
   end

   // interrupt requests lag the flags by one cycle to come from flops
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_irq   <= 1'b0;
         idle_irq <= 1'b0;
      end
      else
      begin
         rx_irq   <= ctrl[CT_RX_IRQ_EN] && (flags[ST_RX_FULL] || flags[ST_OVERRUN]);
         idle_irq <= ctrl[CT_IDLE_IRQ_EN] && flags[ST_IDLE];
      end
   end

   // shifter controls; accept enable drops one cycle after a framing fault
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_accept_en     <= 1'b1;
         frame_len_sel    <= 1'b0;
         parity_enable    <= 1'b0;
         parity_sense     <= 1'b0;
         receiver_standby <= 1'b0;
      end
      else
      begin
         rx_accept_en     <= !flags[ST_FRAMING];
         frame_len_sel    <= ctrl[CT_FRAME_LEN];
         parity_enable    <= ctrl[CT_PARITY_EN];
         parity_sense     <= ctrl[CT_PARITY_SENSE];
         receiver_standby <= ctrl[CT_STANDBY];
      end
   end
endmodule
`default_nettype wire

//--- test/rsf_props.sv
// assertion checker for the receive status flag block
`timescale 1ns/1ps
`default_nettype none
module rsf_props
   import rsf_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   input wire logic              ref_clk,
   input wire logic              rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata,
   input wire logic              rx_bit_tick,
   input wire logic              rx_frame_done,
   input wire logic              rx_frame_stop,
   input wire logic              rx_accept_en,
   input wire logic              parity_enable,
   input wire logic              receiver_standby,
   input wire logic              rx_irq,
   input wire logic              idle_irq
);
   logic dlo_rd;
   logic ctl_wr;
   // decoded strobes, shared so irq checks can excuse enable changes
   assign dlo_rd = reg_rd && (reg_addr == REG_DATA_LOW);
   assign ctl_wr = reg_wr && (reg_addr == REG_CTRL);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence s_stat_rd;
      reg_rd && (reg_addr == REG_STATUS);
   endsequence
   sequence s_bad_stop;
      rx_frame_done && !rx_frame_stop && rx_accept_en;
   endsequence
   chk_status_top: assert property (s_stat_rd |=> reg_rdata[7:6] == 2'b00)
      else $error("status upper bits not zero");
   chk_fault_drop: assert property ($fell(rx_accept_en) |-> $past(rx_frame_done && !rx_frame_stop, 2))
      else $error("accept dropped without a bad stop bit");
   chk_fault_hold: assert property ($rose(rx_accept_en) |-> $past(dlo_rd, 2))
      else $error("accept returned without data low read");
   chk_rxirq_set: assert property ($rose(rx_irq) |-> $past(rx_frame_done, 2) || $past(ctl_wr, 2))
      else $error("rx irq rose without a frame");
   chk_rxirq_clear: assert property ($fell(rx_irq) |-> $past(dlo_rd, 2) || $past(ctl_wr, 2))
      else $error("rx irq fell without data low read");
   chk_idleirq_set: assert property ($rose(idle_irq) |-> $past(rx_bit_tick, 3) || $past(ctl_wr, 2))
      else $error("idle irq rose without a bit tick");
   chk_idleirq_clear: assert property ($fell(idle_irq) |-> $past(dlo_rd, 2) || $past(ctl_wr, 2))
      else $error("idle irq fell without data low read");
   chk_standby_copy: assert property (ctl_wr |=> ##1 receiver_standby == $past(reg_wdata[CT_STANDBY], 2))
      else $error("standby output does not follow control");
   chk_parity_copy: assert property (ctl_wr |=> ##1 parity_enable == $past(reg_wdata[CT_PARITY_EN], 2))
      else $error("parity enable output does not follow control");
   cov_clear_pair: cover property (s_stat_rd ##1 dlo_rd);
   cov_bad_stop: cover property (s_bad_stop);
endmodule
bind rsf_top rsf_props #(.ADDR_W(ADDR_W)) rsf_props_i (.ref_clk(ref_clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .rx_bit_tick(rx_bit_tick), .rx_frame_done(rx_frame_done), .rx_frame_stop(rx_frame_stop),
   .rx_accept_en(rx_accept_en), .parity_enable(parity_enable), .receiver_standby(receiver_standby),
   .rx_irq(rx_irq), .idle_irq(idle_irq));
`default_nettype wire

//--- test/rsf_far_tx.sv
// far-side serial transmitter model feeding line and shifter strobes
`timescale 1ns/1ps
`default_nettype none
module rsf_far_tx
(
   input  wire logic  ref_clk,
   output logic       rx_line,
   output logic       rx_bit_tick,
   output logic       rx_frame_done,
   output logic [8:0] rx_frame_data,
   output logic       rx_frame_noise,
   output logic       rx_frame_stop
);
   // line idles high; frame fields hold junk outside done
   initial
   begin
      rx_line = 1'b1;
      rx_bit_tick = 1'b0;
      rx_frame_done = 1'b0;
      rx_frame_data = 9'h1FF;
      rx_frame_noise = 1'b1;
      rx_frame_stop = 1'b0;
   end
   task automatic tick;
      @(posedge ref_clk);
      rx_bit_tick <= 1'b1;
      @(posedge ref_clk);
      rx_bit_tick <= 1'b0;
   endtask
   // extra edges cover the hit pulse and flag update
   task automatic idle_bits(input int n);
      repeat (n) tick();
      repeat (3) @(posedge ref_clk);
   endtask
   // low tick restarts the idle count, as a start bit would
   task automatic line_low;
      @(posedge ref_clk);
      rx_line <= 1'b0;
      repeat (3) @(posedge ref_clk);
      tick();
      rx_line <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask
   // a frame is a start bit followed by the shifter's done strobe
   task automatic frame(input logic [8:0] d, input logic nz, input logic stop);
      line_low();
      rx_frame_done <= 1'b1;
      rx_frame_data <= d;
      rx_frame_noise <= nz;
      rx_frame_stop <= stop;
      @(posedge ref_clk);
      rx_frame_done <= 1'b0;
      rx_frame_data <= ~d;
      rx_frame_noise <= ~nz;
      rx_frame_stop <= ~stop;
      repeat (2) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

//--- test/rsf_top_test.sv
// self-checking bench for the receive status flag block
`timescale 1ns/1ps
`default_nettype none
module rsf_top_test
   import rsf_pkg::*;
;
   logic       ref_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       rx_line, rx_bit_tick, rx_frame_done, rx_frame_noise, rx_frame_stop;
   logic [8:0] rx_frame_data;
   logic       rx_accept_en, frame_len_sel, parity_enable, parity_sense, receiver_standby;
   logic       rx_irq, idle_irq;
   int         mismatches = 0;
   int         check_count = 0;
   always #5 ref_clk = ~ref_clk;
   rsf_top rsf_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_line(rx_line), .rx_bit_tick(rx_bit_tick),
      .rx_frame_done(rx_frame_done), .rx_frame_data(rx_frame_data), .rx_frame_noise(rx_frame_noise),
      .rx_frame_stop(rx_frame_stop), .rx_accept_en(rx_accept_en), .frame_len_sel(frame_len_sel),
      .parity_enable(parity_enable), .parity_sense(parity_sense), .receiver_standby(receiver_standby),
      .rx_irq(rx_irq), .idle_irq(idle_irq));
   rsf_far_tx rsf_far_tx_i (.ref_clk(ref_clk), .rx_line(rx_line), .rx_bit_tick(rx_bit_tick),
      .rx_frame_done(rx_frame_done), .rx_frame_data(rx_frame_data), .rx_frame_noise(rx_frame_noise),
      .rx_frame_stop(rx_frame_stop));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so sample there
   task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(n, reg_rdata, e);
   endtask
   // watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      complete_run();
   end
   // main sequence
   initial
   begin
      reg_addr <= 4'h0;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      rc("status", REG_STATUS, 8'h00);
      rc("unmapped", 4'h0, 8'h00);
      wr(REG_STATUS, 8'hFF);
      rc("status", REG_STATUS, 8'h00);
      wr(REG_CTRL, 8'h28);
      rsf_far_tx_i.frame(9'h05A, 1'b0, 1'b1);
      chk("rx_irq", {7'h00, rx_irq}, 8'h01);
      chk("parity_enable", {7'h00, parity_enable}, 8'h01);
      rc("data", REG_DATA_LOW, 8'h5A);
      rc("status", REG_STATUS, 8'h20);
      rc("data", REG_DATA_LOW, 8'h5A);
      rc("status", REG_STATUS, 8'h00);
      chk("rx_irq", {7'h00, rx_irq}, 8'h00);
      rsf_far_tx_i.frame(9'h001, 1'b1, 1'b1);
      rsf_far_tx_i.frame(9'h0FF, 1'b0, 1'b1);
      rc("status", REG_STATUS, 8'h2D);
      rc("data", REG_DATA_LOW, 8'h01);
      rc("status", REG_STATUS, 8'h00);
      rsf_far_tx_i.frame(9'h003, 1'b0, 1'b1);
      rc("status", REG_STATUS, 8'h20);
      rsf_far_tx_i.frame(9'h003, 1'b0, 1'b1);
      rc("data", REG_DATA_LOW, 8'h03);
      rc("status", REG_STATUS, 8'h08);
      rc("data", REG_DATA_LOW, 8'h03);
      rc("status", REG_STATUS, 8'h00);
      rsf_far_tx_i.frame(9'h003, 1'b0, 1'b0);
      rc("status", REG_STATUS, 8'h22);
      chk("rx_accept_en", {7'h00, rx_accept_en}, 8'h00);
      rsf_far_tx_i.frame(9'h030, 1'b0, 1'b1);
      rc("status", REG_STATUS, 8'h22);
      rc("data", REG_DATA_LOW, 8'h03);
      rc("status", REG_STATUS, 8'h00);
      chk("rx_accept_en", {7'h00, rx_accept_en}, 8'h01);
      wr(REG_CTRL, 8'h10);
      rsf_far_tx_i.idle_bits(9);
      rc("status", REG_STATUS, 8'h00);
      rsf_far_tx_i.idle_bits(1);
      chk("idle_irq", {7'h00, idle_irq}, 8'h01);
      rc("status", REG_STATUS, 8'h10);
      rc("data", REG_DATA_LOW, 8'h03);
      rc("status", REG_STATUS, 8'h00);
      // a bare break restarts the count, yet no frame has reopened idle
      rsf_far_tx_i.line_low();
      rsf_far_tx_i.idle_bits(11);
      rc("status", REG_STATUS, 8'h00);
      wr(REG_CTRL, 8'h90);
      rsf_far_tx_i.frame(9'h003, 1'b0, 1'b1);
      chk("frame_len_sel", {7'h00, frame_len_sel}, 8'h01);
      rc("status", REG_STATUS, 8'h20);
      rc("data", REG_DATA_LOW, 8'h03);
      rsf_far_tx_i.idle_bits(10);
      rc("status", REG_STATUS, 8'h00);
      rsf_far_tx_i.idle_bits(1);
      rc("status", REG_STATUS, 8'h10);
      rc("data", REG_DATA_LOW, 8'h03);
      wr(REG_CTRL, 8'h02);
      rsf_far_tx_i.frame(9'h003, 1'b0, 1'b1);
      rc("status", REG_STATUS, 8'h20);
      rc("data", REG_DATA_LOW, 8'h03);
      rsf_far_tx_i.idle_bits(11);
      rc("status", REG_STATUS, 8'h00);
      // odd parity sense on a short frame with even data
      wr(REG_CTRL, 8'h0C);
      rsf_far_tx_i.frame(9'h003, 1'b0, 1'b1);
      chk("parity_sense", {7'h00, parity_sense}, 8'h01);
      rc("status", REG_STATUS, 8'h21);
      rc("data", REG_DATA_LOW, 8'h03);
      rc("status", REG_STATUS, 8'h00);
      // nine-bit frame, parity over all nine bits is good
      wr(REG_CTRL, 8'h8C);
      rsf_far_tx_i.frame(9'h103, 1'b0, 1'b1);
      rc("status", REG_STATUS, 8'h20);
      rc("data_high", REG_DATA_HIGH, 8'h80);
      rc("data", REG_DATA_LOW, 8'h03);
      rc("status", REG_STATUS, 8'h00);
      // a reset between status read and data read drops the half-done clear
      rsf_far_tx_i.frame(9'h007, 1'b1, 1'b1);
      rc("status", REG_STATUS, 8'h24);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      rsf_far_tx_i.frame(9'h005, 1'b0, 1'b1);
      rc("data", REG_DATA_LOW, 8'h05);
      rc("status", REG_STATUS, 8'h20);
      complete_run();
   end
endmodule
`default_nettype wire
